// ==== nand_pin_pkg.sv ====
// Overview of operation
// - All timing counts from the one core clock.
// - Commands, addresses, data share one byte bus.
// - Ready/busy low means busy, high ready.
// - Bus held valid around write strobe rise.
// - Command latch high at rise: command byte.
// - Address latch high at rise: address byte.
// - Eight active-low chip selects, dual-die capable.
// - Page sizes 512 bytes or 2 kilobytes.
// - Per 256 bytes: fix one, detect two.
// - Strobe cycle grades 30, 50, 100 ns.
// - Activity indicator low from read/write to release, else released.
// - Alive indicator low only once initialised.
// - Write lock waits for pending operation end.
// - Protect switch low: report, lock, refuse config.
package nand_pin_pkg;

	// ***************************************************************
	// Clock and timing
	// ***************************************************************
	localparam int CLK_MHZ = 100; // Core clock rate
	localparam int REF_MHZ = 24; // Reference oscillator rate
	localparam int GRADE_FAST_NS = 30; // Strobe cycle, fast grade
	localparam int GRADE_MID_NS = 50; // Strobe cycle, middle grade
	localparam int GRADE_SLOW_NS = 100; // Strobe cycle, slow grade
	localparam int FAST_CYC = (GRADE_FAST_NS * CLK_MHZ + 999) / 1000;
	localparam int MID_CYC = (GRADE_MID_NS * CLK_MHZ + 999) / 1000;
	localparam int SLOW_CYC = (GRADE_SLOW_NS * CLK_MHZ + 999) / 1000;
	// Low phase rounds up, high phase takes the rest
	localparam logic [3:0] FAST_LOW = 4'((FAST_CYC + 1) / 2);
	localparam logic [3:0] FAST_HIGH = 4'(FAST_CYC - (FAST_CYC + 1) / 2);
	localparam logic [3:0] MID_LOW = 4'((MID_CYC + 1) / 2);
	localparam logic [3:0] MID_HIGH = 4'(MID_CYC - (MID_CYC + 1) / 2);
	localparam logic [3:0] SLOW_LOW = 4'((SLOW_CYC + 1) / 2);
	localparam logic [3:0] SLOW_HIGH = 4'(SLOW_CYC - (SLOW_CYC + 1) / 2);
	localparam logic [3:0] CAPTURE_CYC = 4'h2; // Input synchroniser depth
	localparam int SETTLE_NS = 100; // Wait before sampling ready/busy
	localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS * CLK_MHZ) / 1000);
	localparam logic [7:0] REF_EDGES_INIT = 8'h10; // Reference edges before alive

	// ***************************************************************
	// Page and chip layout
	// ***************************************************************
	localparam logic [10:0] PAGE_SMALL_LAST = 11'h1FF; // 512-byte page
	localparam logic [10:0] PAGE_LARGE_LAST = 11'h7FF; // 2-kilobyte page
	localparam logic [7:0] ECC_UNIT_LAST = 8'hFF; // 256-byte unit
	localparam int CHIP_COUNT = 8;
	localparam int ECC_BITS = 22; // 16 line parity, 6 column parity
	localparam logic [7:0] CS_NONE = 8'hFF; // All chip selects off
	localparam logic [7:0] CS_ONE = 8'h01;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [2:0] {
		OP_CMD = 3'b000,
		OP_ADDR = 3'b001,
		OP_WRITE = 3'b010,
		OP_READ = 3'b011,
		OP_WAIT = 3'b100,
		OP_RELEASE = 3'b101
	} op_e;
	typedef enum logic [1:0] {
		GRADE_30 = 2'b00,
		GRADE_50 = 2'b01,
		GRADE_100 = 2'b10
	} grade_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b011,
		ST_SETTLE = 3'b100,
		ST_WAIT = 3'b101
	} state_e;
	typedef enum logic [1:0] {
		ECC_CLEAN = 2'b00,
		ECC_FIXED = 2'b01,
		ECC_CODE_ERR = 2'b10,
		ECC_FAIL = 2'b11
	} ecc_e;
	typedef struct packed {
		op_e op;
		logic [7:0] data;
		logic [2:0] chip;
		logic cfgArea;
	} req_s;

endpackage

// ==== nand_byte_buffer.sv ====
`timescale 1ns/1ps
module nand_byte_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Filling side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	// ***************************************************************
	// Storage
	// ***************************************************************
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH]; // Entry 0 is the head
	logic [CW-1:0] count_q; // Words held
	logic [CW-1:0] count_d;
	logic [CW-1:0] wrIdx; // Slot the new word lands in
	logic inReady_q;
	logic outValid_q;
	wire push = inValid && inReady_q;
	wire pop = outValid_q && outReady;

	// Elaboration check: one entry alone would drop a word on a stall
	if (DEPTH < 2) begin : gDepthCheck
		$error("buffer depth below two cannot hold a stalled word");
	end

	assign wrIdx = pop ? count_q - CW'(1) : count_q;
	assign count_d = count_q + CW'(push) - CW'(pop);
	assign inReady = inReady_q;
	assign outValid = outValid_q;
	assign outData = mem_q[0];

	// Per entry: shift toward head on pop, load on push
	for (genvar i = 0; i < DEPTH; i++) begin : gEntry
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				mem_q[i] <= '0;
			end else if (push && wrIdx == CW'(i)) begin
				mem_q[i] <= inData;
			end else if (pop) begin
				mem_q[i] <= (i + 1 < DEPTH) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
			end
		end
	end

	// Flags kept as flops so both handshakes are glitch free
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= '0;
			inReady_q <= 1'b0;
			outValid_q <= 1'b0;
		end else begin
			count_q <= count_d;
			inReady_q <= count_d < CW'(DEPTH);
			outValid_q <= count_d != '0;
		end
	end

endmodule // nand_byte_buffer

// ==== nand_flash_pin_interface.sv ====
`timescale 1ns/1ps
module nand_flash_pin_interface #(
	parameter int RD_DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Operation requests
	input wire logic reqValid,
	input wire nand_pin_pkg::req_s req,
	output logic reqReady,
	// Configuration
	input wire nand_pin_pkg::grade_e flashGrade,
	input wire logic pageLarge,
	// Read data stream
	output logic rdValid,
	output logic [7:0] rdData,
	input wire logic rdReady,
	// Error correction
	output logic [21:0] eccCode,
	output logic eccCodeValid,
	input wire logic eccCheckValid,
	input wire logic [21:0] eccStored,
	output nand_pin_pkg::ecc_e eccStatus,
	output logic eccStatusValid,
	output logic [7:0] eccFixByte,
	output logic [2:0] eccFixBit,
	// Status
	output logic mediaProtected,
	output logic cfgWriteRefused,
	output logic pageEnd,
	// Flash bus pins
	input wire logic [7:0] flashDataIn,
	output logic [7:0] flashDataOut,
	output logic flashDataOe,
	output logic writeStrobeN,
	output logic read_strobe_a_n,
	output logic read_strobe_b_n,
	output logic cmdLatch,
	output logic addrLatch,
	output logic [7:0] chipSelectN,
	input wire logic ready_busy_in_a,
	input wire logic ready_busy_in_b,
	// Protection and indicators
	input wire logic protect_switch_in_n,
	output logic flash_write_lock_n,
	output logic flashWriteLockOe,
	output logic activity_indicator_n,
	output logic activityOe,
	output logic alive_indicator_n,
	output logic aliveOe,
	input wire logic ref_osc_in
);
	import nand_pin_pkg::*;

	// Elaboration check: the read path assumes a two-deep buffer
	if (RD_DEPTH != 2) begin : gDepthCheck
		$error("read buffer is sized for exactly two entries");
	end

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [7:0] dataSync1_q, dataSync2_q; // Flash bus input
	logic [1:0] rbSync1_q, rbSync2_q; // Ready/busy lines
	logic protSync1_q, protSync2_q; // Protect switch
	logic refSync1_q, refSync2_q, refSync3_q; // Reference oscillator

	// Two flops per pin, three on the reference oscillator so its edge can be found
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dataSync1_q <= 8'h00;
			dataSync2_q <= 8'h00;
			rbSync1_q <= 2'h0;
			rbSync2_q <= 2'h0;
			protSync1_q <= 1'b1;
			protSync2_q <= 1'b1;
			refSync1_q <= 1'b0;
			refSync2_q <= 1'b0;
			refSync3_q <= 1'b0;
		end else begin
			dataSync1_q <= flashDataIn;
			dataSync2_q <= dataSync1_q;
			rbSync1_q <= {ready_busy_in_b, ready_busy_in_a};
			rbSync2_q <= rbSync1_q;
			protSync1_q <= protect_switch_in_n;
			protSync2_q <= protSync1_q;
			refSync1_q <= ref_osc_in;
			refSync2_q <= refSync1_q;
			refSync3_q <= refSync2_q;
		end
	end

	// ***************************************************************
	// Initialisation from the reference oscillator
	// ***************************************************************
	wire refEdge = refSync2_q && !refSync3_q; // Rising reference edge
	logic [7:0] refCount_q;
	logic initDone_q;

	// Counting reference edges proves the oscillator runs before we go live
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			refCount_q <= 8'h00;
			initDone_q <= 1'b0;
		end else if (refEdge && !initDone_q) begin
			refCount_q <= refCount_q + 8'h01;
			initDone_q <= (refCount_q + 8'h01) == REF_EDGES_INIT;
		end
	end

	// ***************************************************************
	// Sequencer decode
	// ***************************************************************
	state_e state_q, stateNext;
	op_e opCur_q;
	logic [2:0] chipCur_q;
	grade_e gradeCur_q;
	logic [3:0] phaseCnt_q;
	logic reqReady_q;
	logic bufInReady;
	logic activityOe_q;
	wire lockReq = !protSync2_q; // Switch low asks for protection
	wire take = reqValid && reqReady_q;
	wire refuse = take && req.op == OP_WRITE && req.cfgArea && lockReq;
	wire busOp = req.op inside {OP_CMD, OP_ADDR, OP_WRITE, OP_READ};
	op_e opNext;
	assign opNext = take ? req.op : opCur_q;
	wire isRead = opCur_q == OP_READ;
	wire phaseLast = phaseCnt_q == 4'h1;
	wire rbSel = chipCur_q[2] ? rbSync2_q[1] : rbSync2_q[0];
	wire chipReady = rbSel; // Low is busy, high is ready
	// Strobe phases per grade
	wire [3:0] lowCyc = gradeCur_q == GRADE_30 ? FAST_LOW :
		gradeCur_q == GRADE_50 ? MID_LOW : SLOW_LOW;
	wire [3:0] highRaw = gradeCur_q == GRADE_30 ? FAST_HIGH :
		gradeCur_q == GRADE_50 ? MID_HIGH : SLOW_HIGH;
	// Reads stretch the high phase until the synchroniser has the byte
	wire [3:0] highCyc = (isRead && highRaw < CAPTURE_CYC) ? CAPTURE_CYC : highRaw;
	wire byteDone = state_q == ST_HIGH && phaseLast && (isRead || opCur_q == OP_WRITE);
	wire busyNext = stateNext inside {ST_SETUP, ST_LOW, ST_HIGH};

	// Next state
	always_comb begin
		stateNext = state_q;
		case (state_q)
			ST_IDLE: begin
				if (take && !refuse && busOp) begin
					stateNext = ST_SETUP;
				end else if (take && req.op == OP_WAIT) begin
					stateNext = ST_SETTLE;
				end
			end
			ST_SETUP: begin
				// A full read buffer holds the sequencer here
				if (!isRead || bufInReady) begin
					stateNext = ST_LOW;
				end
			end
			ST_LOW: begin
				if (phaseLast) begin
					stateNext = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (phaseLast) begin
					stateNext = ST_IDLE;
				end
			end
			ST_SETTLE: begin
				if (phaseLast) begin
					stateNext = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (chipReady) begin
					stateNext = ST_IDLE;
				end
			end
			default: begin
				stateNext = ST_IDLE;
			end
		endcase
	end

	// ***************************************************************
	// Sequencer registers
	// ***************************************************************
	// State, operation and phase counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			opCur_q <= OP_RELEASE;
			chipCur_q <= 3'h0;
			gradeCur_q <= GRADE_100;
			phaseCnt_q <= 4'h0;
			reqReady_q <= 1'b0;
		end else begin
			state_q <= stateNext;
			opCur_q <= opNext;
			if (take) begin
				chipCur_q <= req.chip;
				gradeCur_q <= flashGrade;
			end
			if (stateNext == ST_LOW && state_q != ST_LOW) begin
				phaseCnt_q <= lowCyc;
			end else if (stateNext == ST_HIGH && state_q != ST_HIGH) begin
				phaseCnt_q <= highCyc;
			end else if (stateNext == ST_SETTLE) begin
				phaseCnt_q <= state_q == ST_SETTLE ? phaseCnt_q - 4'h1 : SETTLE_CYC;
			end else if (phaseCnt_q != 4'h0) begin
				phaseCnt_q <= phaseCnt_q - 4'h1;
			end
			reqReady_q <= stateNext == ST_IDLE && initDone_q && !take;
		end
	end

	// ***************************************************************
	// Flash pin drivers
	// ***************************************************************
	logic [7:0] dataOut_q;
	logic dataOe_q, weN_q, reAN_q, reBN_q, cle_q, ale_q;
	logic [7:0] csN_q;

	// Strobes and latches follow the next state so pins change on one edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dataOut_q <= 8'h00;
			dataOe_q <= 1'b0; // Bus undriven
			weN_q <= 1'b1;
			reAN_q <= 1'b1;
			reBN_q <= 1'b1;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			csN_q <= CS_NONE;
		end else begin
			if (take) begin
				dataOut_q <= req.data; // Held through the high phase
			end
			dataOe_q <= busyNext && opNext != OP_READ;
			weN_q <= !(stateNext == ST_LOW && opNext != OP_READ);
			reAN_q <= !(stateNext == ST_LOW && opNext == OP_READ && !chipCur_q[2]);
			reBN_q <= !(stateNext == ST_LOW && opNext == OP_READ && chipCur_q[2]);
			cle_q <= busyNext && opNext == OP_CMD;
			ale_q <= busyNext && opNext == OP_ADDR;
			if (take && !refuse && busOp) begin
				csN_q <= ~(CS_ONE << req.chip); // Single select
			end else if (take && req.op == OP_RELEASE) begin
				csN_q <= CS_NONE;
			end
		end
	end

	// ***************************************************************
	// Read path and page column
	// ***************************************************************
	wire [7:0] byteVal = isRead ? dataSync2_q : dataOut_q;
	logic [10:0] column_q;
	logic pageEnd_q;
	wire [10:0] pageLastCol = pageLarge ? PAGE_LARGE_LAST : PAGE_SMALL_LAST;

	// Column counts data bytes; a command starts a fresh page access
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			column_q <= 11'h000;
			pageEnd_q <= 1'b0;
		end else begin
			pageEnd_q <= byteDone && column_q == pageLastCol;
			if (take && req.op == OP_CMD) begin
				column_q <= 11'h000;
			end else if (byteDone) begin
				column_q <= column_q == pageLastCol ? 11'h000 : column_q + 11'h001;
			end
		end
	end

	// Two-entry buffer so a stalled receiver loses no byte
	nand_byte_buffer #(.WIDTH(8), .DEPTH(RD_DEPTH)) uRdBuf (
		.clk(clk),
		.sys_rst(sys_rst),
		.inValid(byteDone && isRead),
		.inData(dataSync2_q),
		.inReady(bufInReady),
		.outValid(rdValid),
		.outData(rdData),
		.outReady(rdReady)
	);

	// ***************************************************************
	// Error correction code
	// ***************************************************************
	logic [ECC_BITS-1:0] eccAcc_q, eccCode_q, eccContrib;
	logic eccCodeValid_q, eccStatusValid_q;
	ecc_e eccStatus_q;
	logic [7:0] fixByte_q;
	logic [2:0] fixBit_q;
	wire bytePar = ^byteVal;
	wire unitLast = column_q[7:0] == ECC_UNIT_LAST;

	// Line parity per index bit, column parity per bit-position bit
	for (genvar k = 0; k < 8; k++) begin : gLine
		assign eccContrib[2*k] = bytePar && !column_q[k];
		assign eccContrib[2*k+1] = bytePar && column_q[k];
	end
	for (genvar k = 0; k < 3; k++) begin : gCol
		logic [7:0] selMask;
		for (genvar j = 0; j < 8; j++) begin : gBit
			assign selMask[j] = ((j >> k) & 1) == 1;
		end
		assign eccContrib[16+2*k] = ^(byteVal & ~selMask);
		assign eccContrib[17+2*k] = ^(byteVal & selMask);
	end

	wire [ECC_BITS-1:0] syndrome = eccCode_q ^ eccStored;
	logic [10:0] pairDiff;
	logic [10:0] oddBits;
	for (genvar p = 0; p < 11; p++) begin : gPair
		assign pairDiff[p] = syndrome[2*p] ^ syndrome[2*p+1];
		assign oddBits[p] = syndrome[2*p+1];
	end
	// Single error flips one of each pair; one stray bit is a code error
	wire ecc_e eccClass = syndrome == '0 ? ECC_CLEAN :
		&pairDiff ? ECC_FIXED :
		$countones(syndrome) == 1 ? ECC_CODE_ERR : ECC_FAIL;

	// Accumulate per unit, publish on the unit's last byte, check on demand
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			eccAcc_q <= '0;
			eccCode_q <= '0;
			eccCodeValid_q <= 1'b0;
			eccStatus_q <= ECC_CLEAN;
			eccStatusValid_q <= 1'b0;
			fixByte_q <= 8'h00;
			fixBit_q <= 3'h0;
		end else begin
			eccCodeValid_q <= byteDone && unitLast;
			eccStatusValid_q <= eccCheckValid;
			if (byteDone) begin
				eccAcc_q <= (column_q[7:0] == 8'h00) ? eccContrib : eccAcc_q ^ eccContrib;
			end
			if (byteDone && unitLast) begin
				eccCode_q <= eccAcc_q ^ eccContrib;
			end
			if (eccCheckValid) begin
				eccStatus_q <= eccClass;
				fixByte_q <= oddBits[7:0];
				fixBit_q <= oddBits[10:8];
			end
		end
	end

	// ***************************************************************
	// Protection and indicators
	// ***************************************************************
	logic lockN_q, lockOe_q, aliveOe_q, mediaProt_q, refused_q;
	wire pending = activityOe_q || state_q != ST_IDLE || rdValid;

	// Lock is withheld until the pending operation drains
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lockN_q <= 1'b1;
			lockOe_q <= 1'b0;
			aliveOe_q <= 1'b0;
			activityOe_q <= 1'b0;
			mediaProt_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			aliveOe_q <= initDone_q;
			lockOe_q <= initDone_q;
			mediaProt_q <= lockReq;
			refused_q <= refuse;
			if (!lockReq) begin
				lockN_q <= 1'b1;
			end else if (!pending) begin
				lockN_q <= 1'b0;
			end
			if (take && (req.op == OP_WRITE || req.op == OP_READ) && !refuse) begin
				activityOe_q <= 1'b1;
			end else if (take && req.op == OP_RELEASE) begin
				activityOe_q <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// Output wiring
	// ***************************************************************
	assign reqReady = reqReady_q;
	assign flashDataOut = dataOut_q;
	assign flashDataOe = dataOe_q;
	assign writeStrobeN = weN_q;
	assign read_strobe_a_n = reAN_q;
	assign read_strobe_b_n = reBN_q;
	assign cmdLatch = cle_q;
	assign addrLatch = ale_q;
	assign chipSelectN = csN_q;
	assign eccCode = eccCode_q;
	assign eccCodeValid = eccCodeValid_q;
	assign eccStatus = eccStatus_q;
	assign eccStatusValid = eccStatusValid_q;
	assign eccFixByte = fixByte_q;
	assign eccFixBit = fixBit_q;
	assign mediaProtected = mediaProt_q;
	assign cfgWriteRefused = refused_q;
	assign pageEnd = pageEnd_q;
	assign flash_write_lock_n = lockN_q;
	assign flashWriteLockOe = lockOe_q;
	assign activity_indicator_n = 1'b0; // Open drain: only sinks
	assign activityOe = activityOe_q;
	assign alive_indicator_n = 1'b0;
	assign aliveOe = aliveOe_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_latch_exclusive: assert property (!(cle_q && ale_q))
		else $error("command and address latch high together");
	chk_select_onehot: assert property ($onehot0(~csN_q))
		else $error("more than one chip select active");
	chk_bus_at_rise: assert property ($rose(weN_q) |-> dataOe_q && $stable(dataOut_q))
		else $error("bus not held at write strobe rise");
	chk_idle_strobes: assert property (state_q == ST_IDLE |-> weN_q && reAN_q && reBN_q)
		else $error("strobe low while idle");
	chk_read_undriven: assert property (!(reAN_q && reBN_q) |-> !dataOe_q)
		else $error("bus driven during read strobe");
	chk_slow_low: assert property ($fell(weN_q) && gradeCur_q == GRADE_100 |->
		!weN_q [*5] ##1 weN_q)
		else $error("slow grade write low phase not five cycles");
	chk_lock_waits: assert property ($fell(lockN_q) |-> $past(!pending))
		else $error("write lock applied during pending operation");
	chk_busy_holds: assert property (state_q == ST_WAIT && !chipReady |=> state_q == ST_WAIT)
		else $error("left busy wait while chip busy");
	chk_refused_quiet: assert property (refuse |=> state_q == ST_IDLE && refused_q)
		else $error("refused configuration write reached the bus");
	chk_alive_init: assert property ($rose(aliveOe_q) |-> $past(initDone_q))
		else $error("alive indicator before initialisation");

endmodule // nand_flash_pin_interface

// ==== flash_chip_model.sv ====
`timescale 1ns/1ps
module flash_chip_model (
	// Flash bus
	input wire logic [7:0] chipSelectN,
	input wire logic writeStrobeN,
	input wire logic readStrobeN,
	input wire logic cmdLatch,
	input wire logic addrLatch,
	input wire logic [7:0] busIn,
	output logic [7:0] busOut,
	// Status seen by the bench
	input wire logic busy,
	output logic readyBusyN,
	output logic [7:0] lastCmd,
	output logic [7:0] lastAddr,
	output logic [7:0] lastData,
	output logic [7:0] csSeen
);
	logic [7:0] col = 8'h00; // Column counter
	wire sel = chipSelectN != 8'hFF; // Any chip selected
	initial busOut = 8'h00;
	// Busy pulls the line low, pull-up lifts it
	assign readyBusyN = !busy;
	// Bytes latched only on write strobe rise
	always @(posedge writeStrobeN) if (sel) begin
		csSeen = chipSelectN;
		if (cmdLatch) begin
			lastCmd = busIn;
			col = 8'h00;
		end else if (addrLatch) lastAddr = busIn;
		else lastData = busIn;
	end
	// Next byte and column step on read strobe fall
	always @(negedge readStrobeN) if (sel) begin
		busOut = 8'hA0 + col;
		col = col + 8'h01;
	end
	// Deselected: stale byte inverted, never left looking valid
	always @(chipSelectN) if (!sel) busOut = ~busOut;
endmodule // flash_chip_model

// ==== nand_flash_pin_interface_test.sv ====
`timescale 1ns/1ps
module nand_flash_pin_interface_test;
	import nand_pin_pkg::*;
	// ***************************************************************
	// Signals
	// ***************************************************************
	logic clk, sys_rst, reqValid, reqReady, pageLarge, rdValid, rdReady, eccCodeValid;
	logic eccCheckValid, eccStatusValid, mediaProtected, cfgWriteRefused, pageEnd;
	logic flashDataOe, writeStrobeN, read_strobe_a_n, read_strobe_b_n, cmdLatch, addrLatch;
	logic ready_busy_in_a, ready_busy_in_b, protect_switch_in_n, flash_write_lock_n;
	logic flashWriteLockOe, activity_indicator_n, activityOe, alive_indicator_n, aliveOe;
	logic ref_osc_in, busy, rbN;
	logic [7:0] rdData, eccFixByte, flashDataIn, flashDataOut, chipSelectN, busOut;
	logic [7:0] lastCmd, lastAddr, lastData, csSeen;
	logic [21:0] eccCode, eccStored;
	logic [2:0] eccFixBit;
	req_s req;
	grade_e flashGrade;
	ecc_e eccStatus;
	int n_fail = 0;
	int tests_run = 0;
	int refused = 0, pageEnds = 0, unitEnds = 0; // Pulses seen
	// Resolved data bus
	assign flashDataIn = flashDataOe ? flashDataOut : busOut;
	assign ready_busy_in_a = rbN;
	assign ready_busy_in_b = 1'b1; // Other group idle, pulled up
	nand_flash_pin_interface dut (.*);
	flash_chip_model flash (.chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
		.readStrobeN(read_strobe_a_n & read_strobe_b_n), .cmdLatch(cmdLatch),
		.addrLatch(addrLatch), .busIn(flashDataIn), .busOut(busOut), .busy(busy),
		.readyBusyN(rbN), .lastCmd(lastCmd), .lastAddr(lastAddr), .lastData(lastData),
		.csSeen(csSeen));
	// ***************************************************************
	// Clocks and helpers
	// ***************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Reference oscillator, near 24 MHz
	initial begin
		ref_osc_in = 1'b0;
		forever #21 ref_osc_in = ~ref_osc_in;
	end
	// Pulses last one cycle, so count them here
	always @(posedge clk) begin
		if (cfgWriteRefused === 1'b1) refused++;
		if (pageEnd === 1'b1) pageEnds++;
		if (eccCodeValid === 1'b1) unitEnds++;
	end
	task conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Bounded wait for the block to accept again
	task waitReady();
		for (int i = 0; i < 400 && reqReady !== 1'b1; i++) tick(1);
		if (reqReady !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: request never accepted", $time);
			conclude();
		end
	endtask
	task issue(input op_e o, input logic [7:0] d, input logic [2:0] c, input logic cfg);
		waitReady();
		req = '{o, d, c, cfg};
		reqValid = 1'b1;
		tick(1);
		reqValid = 1'b0;
		tick(1);
	endtask
	task op(input op_e o, input logic [7:0] d, input logic [2:0] c, input logic cfg);
		issue(o, d, c, cfg);
		waitReady();
	endtask
	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task s_write();
		for (int g = 0; g < 3; g++) begin
			flashGrade = grade_e'(g);
			op(OP_CMD, 8'h80, 3'h3, 1'b0);
			op(OP_ADDR, 8'h12 + 8'(g), 3'h3, 1'b0);
			op(OP_WRITE, 8'h5A ^ 8'(g), 3'h3, 1'b0);
			check(lastCmd, 8'h80);
			check(lastAddr, 8'h12 + 8'(g));
			check(lastData, 8'h5A ^ 8'(g));
			check(csSeen, 8'hF7);
			check({6'h00, activityOe, activity_indicator_n}, 8'h02);
			op(OP_RELEASE, 8'h00, 3'h3, 1'b0);
			check({7'h00, activityOe}, 8'h00);
			check(chipSelectN, 8'hFF);
		end
	endtask
	task s_read();
		rdReady = 1'b0;
		op(OP_CMD, 8'h00, 3'h5, 1'b0);
		op(OP_READ, 8'h00, 3'h5, 1'b0);
		op(OP_READ, 8'h00, 3'h5, 1'b0);
		check({rdValid, 7'h00}, 8'h80);
		check(rdData, 8'hA0);
		rdReady = 1'b1;
		tick(1);
		check(rdData, 8'hA1);
		tick(1);
		rdReady = 1'b0;
		check({rdValid, 7'h00}, 8'h00);
	endtask
	task s_busy();
		busy = 1'b1;
		issue(OP_WAIT, 8'h00, 3'h0, 1'b0);
		tick(40);
		check({7'h00, reqReady}, 8'h00);
		busy = 1'b0;
		waitReady();
		check({7'h00, reqReady}, 8'h01);
	endtask
	task s_protect();
		op(OP_WRITE, 8'h33, 3'h1, 1'b0);
		protect_switch_in_n = 1'b0;
		tick(6);
		check({7'h00, mediaProtected}, 8'h01);
		check({7'h00, flash_write_lock_n}, 8'h01);
		op(OP_WRITE, 8'hC6, 3'h1, 1'b1);
		check(lastData, 8'h33);
		check(8'(refused), 8'h01);
		op(OP_RELEASE, 8'h00, 3'h1, 1'b0);
		tick(4);
		check({7'h00, flash_write_lock_n}, 8'h00);
		protect_switch_in_n = 1'b1;
		tick(6);
		check({6'h00, mediaProtected, flash_write_lock_n}, 8'h01);
	endtask
	// Both page sizes; every unit holds one set bit at byte 5, bit 3
	task s_page();
		flashGrade = GRADE_30;
		for (int pl = 0; pl < 2; pl++) begin
			pageLarge = pl[0];
			op(OP_CMD, 8'h80, 3'h2, 1'b0);
			for (int b = 0; b < 512 + 1536 * pl; b++) begin
				op(OP_WRITE, (b[7:0] == 8'h05) ? 8'h08 : 8'h00, 3'h2, 1'b0);
			end
		end
		// Stored code of an all-zero unit: a single error to locate
		eccCheckValid = 1'b1;
		tick(1);
		eccCheckValid = 1'b0;
		check({5'h00, eccStatusValid, eccStatus}, 8'h05);
		check(eccFixByte, 8'h05);
		check({5'h00, eccFixBit}, 8'h03);
		check(8'(pageEnds), 8'h02);
		check(8'(unitEnds), 8'h0A);
	endtask
	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		sys_rst = 1'b1;
		reqValid = 1'b0;
		req = '0;
		flashGrade = GRADE_30;
		pageLarge = 1'b0;
		rdReady = 1'b0;
		eccCheckValid = 1'b0;
		eccStored = 22'h000000;
		protect_switch_in_n = 1'b1;
		busy = 1'b0;
		tick(20); // Short hold suffices: the block resets on one edge
		check({writeStrobeN, read_strobe_a_n, read_strobe_b_n, flashDataOe}, 8'h0E);
		check({5'h00, aliveOe, flashWriteLockOe, activityOe}, 8'h00);
		sys_rst = 1'b0;
		waitReady();
		check({4'h0, aliveOe, flashWriteLockOe, flash_write_lock_n, alive_indicator_n}, 8'h0E);
		s_write();
		s_read();
		s_busy();
		s_protect();
		s_page();
		conclude();
	end
endmodule // nand_flash_pin_interface_test
